// ==== hdl/debw_defs.svh ====
// constants for the data eeprom block write control
`ifndef DEBW_DEFS_SVH
`define DEBW_DEFS_SVH
`define DEBW_OFS_CTRL 4'h0
`define DEBW_OFS_KEY 4'h4
`define DEBW_OFS_ADDR 4'h8
`define DEBW_OFS_LATCH 4'hC
`define DEBW_CTRL_RESET 16'h0000
`define DEBW_BLOCK_OP 16'h400A
`define DEBW_OP_MASK 16'h407F
`define DEBW_BIT_START 15
`define DEBW_BIT_PERMIT 14
`define DEBW_KEY_FIRST 16'h0055
`define DEBW_KEY_SECOND 16'h00AA
`define DEBW_LATCH_COUNT 16
`define DEBW_WORD_NS 2000
`define DEBW_WORD_CYC ((`DEBW_WORD_NS + 24) / 25)
`endif

// ==== hdl/debw_pkg.sv ====
// types for the data eeprom block write control
package debw_pkg;
	typedef enum logic [1:0] {
		DEBW_IDLE = 2'b00,
		DEBW_PROG = 2'b01,
		DEBW_WAIT = 2'b10
	} debw_state_t;
endpackage : debw_pkg

// ==== hdl/debw_mem_if.sv ====
// interface from control to the eeprom word programmer
`timescale 1ns/1ps
interface debw_mem_if;
	logic go;
	logic [3:0] index;
	logic done;
	modport ctrl (output go, output index, input done);
	modport prog (input go, input index, output done);
endinterface : debw_mem_if

// ==== hdl/debw_word_timer.sv ====
// times one eeprom word program pulse
`timescale 1ns/1ps
`include "debw_defs.svh"
module debw_word_timer
	import debw_pkg::*;
(
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic clk_en,
	debw_mem_if.prog mem
);
	logic [15:0] count;
	logic busy;

	// count a fixed program time, then pulse done
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			count <= 16'h0000;
			busy <= 1'b0;
			mem.done <= 1'b0;
		end
		else if (clk_en)
		begin
			mem.done <= 1'b0;
			if (mem.go && !busy)
			begin
				busy <= 1'b1;
				count <= 16'((`DEBW_WORD_CYC) - 1);
			end
			else if (busy)
			begin
				if (count == 16'h0000)
				begin
					busy <= 1'b0;
					mem.done <= 1'b1;
				end
				else
					count <= count - 16'h0001;
			end
		end
	end
endmodule : debw_word_timer

// ==== hdl/debw_ctrl.sv ====
// data eeprom block write control with avalon register slave
//
// Chosen here: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "debw_defs.svh"
module debw_ctrl
	import debw_pkg::*;
(
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic clk_en,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic table_store_low_word,
	input wire logic [23:0] table_addr,
	input wire logic [15:0] table_data,
	input wire logic power_up_timer_run,
	output logic ee_write,
	output logic [23:0] ee_addr,
	output logic [15:0] ee_data
);
	debw_mem_if mem ();
	logic [15:0] nonvolatile_control;
	logic [23:0] nonvolatile_target_address;
	logic [15:0] latch_mem [0:15];
	logic [4:0] loaded;
	logic key_first_seen;
	logic unlocked;
	logic [3:0] word_idx;
	logic pwrt_s1;
	logic pwrt_s2;
	logic ack;
	debw_state_t state;
	debw_state_t next_state;

	// decode of a register write at a given offset
	// write takes effect only at the edge where waitrequest is low
	function automatic logic wr_at(input logic [3:0] ofs);
		wr_at = avs_write && ack && (avs_address == ofs);
	endfunction : wr_at

	// one wait cycle for every access, answered at the next edge
	assign avs_waitrequest = (avs_read || avs_write) && !ack;

	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
			ack <= 1'b0;
		else if (clk_en)
			ack <= (avs_read || avs_write) && !ack;
	end

	// power-up timer level from outside the clock domain
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			pwrt_s1 <= 1'b1;
			pwrt_s2 <= 1'b1;
		end
		else if (clk_en)
		begin
			pwrt_s1 <= power_up_timer_run;
			pwrt_s2 <= pwrt_s1;
		end
	end

	// table write latches and captured target address
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			nonvolatile_target_address <= 24'h000000;
			loaded <= 5'h00;
		end
		else if (clk_en)
		begin
			if (table_store_low_word && state == DEBW_IDLE)
			begin
				nonvolatile_target_address <= table_addr;
				if (loaded != 5'(`DEBW_LATCH_COUNT))
					loaded <= loaded + 5'h01;
			end
			else if (state == DEBW_WAIT && mem.done && word_idx == 4'hF)
				loaded <= 5'h00;
		end
	end

	// latch storage, index from the low address bits
	always_ff @(posedge ref_clk)
	begin
		if (clk_en && table_store_low_word && state == DEBW_IDLE)
			latch_mem[table_addr[4:1]] <= table_data;
	end

	// unlock key tracking
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			key_first_seen <= 1'b0;
			unlocked <= 1'b0;
		end
		else if (clk_en)
		begin
			if (wr_at(`DEBW_OFS_KEY))
			begin
				key_first_seen <= (avs_writedata[15:0] == `DEBW_KEY_FIRST);
				unlocked <= key_first_seen
					&& (avs_writedata[15:0] == `DEBW_KEY_SECOND);
			end
			else if (wr_at(`DEBW_OFS_CTRL))
			begin
				key_first_seen <= 1'b0;
				unlocked <= 1'b0;
			end
		end
	end

	logic start_req;
	logic start_ok;
	// process form so that the signals read inside the decode wake it up
	always_comb
	begin
		start_req = wr_at(`DEBW_OFS_CTRL) && avs_writedata[`DEBW_BIT_START];
	end
	// start accepted only with unlock, permit, block op, timer expired
	assign start_ok = start_req && unlocked && state == DEBW_IDLE
		&& nonvolatile_control[`DEBW_BIT_PERMIT]
		&& ((nonvolatile_control & `DEBW_OP_MASK) == `DEBW_BLOCK_OP)
		&& !pwrt_s2;

	// control register; permit cleared at power-up
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
			nonvolatile_control <= `DEBW_CTRL_RESET;
		else if (clk_en)
		begin
			if (state == DEBW_WAIT && mem.done && word_idx == 4'hF)
				nonvolatile_control[`DEBW_BIT_START] <= 1'b0;
			else if (start_ok)
				nonvolatile_control[`DEBW_BIT_START] <= 1'b1;
			else if (wr_at(`DEBW_OFS_CTRL) && state == DEBW_IDLE)
			begin
				nonvolatile_control[14:0] <= avs_writedata[14:0];
			end
		end
	end

	// sequencer state
	always_comb
	begin
		next_state = state;
		unique case (state)
			DEBW_IDLE: if (start_ok) next_state = DEBW_PROG;
			DEBW_PROG: next_state = DEBW_WAIT;
			DEBW_WAIT:
			begin
				if (mem.done)
					next_state = (word_idx == 4'hF) ? DEBW_IDLE : DEBW_PROG;
			end
			default: next_state = DEBW_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
			state <= DEBW_IDLE;
		else if (clk_en)
			state <= next_state;
	end

	// word index walks the sixteen latches
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
			word_idx <= 4'h0;
		else if (clk_en)
		begin
			if (state == DEBW_IDLE)
				word_idx <= 4'h0;
			else if (state == DEBW_WAIT && mem.done)
				word_idx <= word_idx + 4'h1;
		end
	end

	assign mem.go = (state == DEBW_PROG);
	assign mem.index = word_idx;

	// eeprom write strobe with registered address and data
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			ee_write <= 1'b0;
			ee_addr <= 24'h000000;
			ee_data <= 16'h0000;
		end
		else if (clk_en)
		begin
			ee_write <= (state == DEBW_WAIT) && mem.done;
			if (state == DEBW_PROG)
			begin
				ee_addr <= {nonvolatile_target_address[23:5], word_idx, 1'b0};
				ee_data <= latch_mem[word_idx];
			end
		end
	end

	// read data register
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
			avs_readdata <= 32'h00000000;
		else if (clk_en && avs_read && !ack)
		begin
			unique case (avs_address)
				`DEBW_OFS_CTRL: avs_readdata <= {16'h0000, nonvolatile_control};
				`DEBW_OFS_ADDR: avs_readdata <= {8'h00, nonvolatile_target_address};
				`DEBW_OFS_LATCH: avs_readdata <= {27'h0000000, loaded};
				default: avs_readdata <= 32'h00000000;
			endcase
		end
	end

	debw_word_timer u_timer (
		.ref_clk(ref_clk),
		.arst_n(arst_n),
		.clk_en(clk_en),
		.mem(mem)
	);
endmodule : debw_ctrl

// ==== dv/debw_ctrl_assertions.sv ====
// checker on the ports of the block write control
`timescale 1ns/1ps
module debw_ctrl_assertions (
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic clk_en,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic power_up_timer_run,
	input wire logic ee_write,
	input wire logic [23:0] ee_addr
);
	// single clock domain
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!arst_n);
	// bus handshake and read data
	a_wait_first: assert property (
		$rose(avs_read | avs_write) |-> avs_waitrequest)
		else $error("no wait on new request");
	a_answer_next: assert property (
		(avs_read | avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("answer not one cycle later");
	a_read_hold: assert property (
		!avs_read ##1 !avs_read |-> $stable(avs_readdata))
		else $error("read data moved without read");
	// word programming pulses
	a_word_gap: assert property (
		ee_write |=> !ee_write [*8])
		else $error("word pulses too close");
	a_timer_block: assert property (
		power_up_timer_run [*4] |-> !ee_write)
		else $error("program while timer runs");
	a_even_addr: assert property (
		ee_write |-> !ee_addr[0])
		else $error("odd word address");
	a_freeze_quiet: assert property (
		!clk_en && !ee_write |=> !ee_write)
		else $error("pulse while frozen");
	a_pulse_cause: assert property (
		ee_write |-> !power_up_timer_run || !$past(power_up_timer_run, 3))
		else $error("pulse without cleared timer");
	// main scenarios
	c_word: cover property (ee_write);
	c_write: cover property (avs_write && !avs_waitrequest);
	c_read: cover property (avs_read && !avs_waitrequest);
endmodule : debw_ctrl_assertions
bind debw_ctrl debw_ctrl_assertions chk_u (.ref_clk, .arst_n, .clk_en, .avs_read, .avs_write,
	.avs_readdata, .avs_waitrequest, .power_up_timer_run, .ee_write, .ee_addr);

// ==== dv/debw_ctrl_bench.sv ====
// self-checking bench for the block write control
`timescale 1ns/1ps
module debw_ctrl_bench
	import debw_pkg::*;
;
	logic ref_clk = 0, arst_n = 0, clk_en = 1, avs_read = 0, avs_write = 0;
	logic table_store_low_word = 0, power_up_timer_run = 1, avs_waitrequest, ee_write;
	logic [3:0] avs_address = 4'h0;
	logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
	logic [23:0] table_addr = 24'h0, ee_addr;
	logic [15:0] table_data = 16'h0, ee_data;
	logic [23:0] seen_addr [16];
	logic [15:0] seen_data [16];
	int mismatches = 0, n_compared = 0, n_words = 0;
	// clock
	always #12.5 ref_clk = ~ref_clk;
	debw_ctrl dut_u (.ref_clk, .arst_n, .clk_en, .avs_address, .avs_read, .avs_write,
		.avs_writedata, .avs_readdata, .avs_waitrequest, .table_store_low_word, .table_addr,
		.table_data, .power_up_timer_run, .ee_write, .ee_addr, .ee_data);
	// record programmed words
	always @(posedge ref_clk)
	begin
		if (ee_write === 1'b1 && n_words < 16)
		begin
			seen_addr[n_words] <= ee_addr;
			seen_data[n_words] <= ee_data;
		end
		if (ee_write === 1'b1)
			n_words <= n_words + 1;
	end
	task report_and_stop;
		$display("mismatches %0d compared %0d", mismatches, n_compared);
		if (mismatches == 0 && n_compared > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : report_and_stop
	task check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	// one bus access, held until waitrequest is seen low
	task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
		int n;
		n = 0;
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		do
		begin
			@(posedge ref_clk);
			n++;
		end
		while (avs_waitrequest !== 1'b0 && n < 50);
		if (n >= 50)
			mismatches++;
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge ref_clk);
	endtask : bus
	task rdchk(input logic [3:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		check(rd, exp);
	endtask : rdchk
	// control, two keys back to back with no other traffic, then start
	task attempt(input logic [31:0] op, input logic [31:0] k1, input logic [31:0] k2);
		bus(1'b1, 4'h0, op);
		bus(1'b1, 4'h4, k1);
		bus(1'b1, 4'h4, k2);
		bus(1'b1, 4'h0, op | 32'h00008000);
	endtask : attempt
	// watchdog
	initial
	begin
		repeat (6000) @(posedge ref_clk);
		mismatches++;
		report_and_stop;
	end
	// main sequence
	initial
	begin
		int n;
		repeat (2) @(posedge ref_clk);
		arst_n <= 1'b1;
		@(posedge ref_clk);
		clk_en <= 1'b0;
		repeat (3) @(posedge ref_clk);
		clk_en <= 1'b1;
		rdchk(4'h0, 32'h0);
		rdchk(4'h2, 32'h0);
		for (int i = 0; i < 16; i++)
		begin
			table_addr <= 24'h7FFC00 + 24'(2 * i);
			table_data <= 16'hA500 + 16'(i);
			table_store_low_word <= 1'b1;
			@(posedge ref_clk);
			table_store_low_word <= 1'b0;
			@(posedge ref_clk);
		end
		rdchk(4'h8, 32'h007FFC1E);
		rdchk(4'hC, 32'd16);
		attempt(32'h0000400A, 32'h55, 32'hAA);
		repeat (200) @(posedge ref_clk);
		check(n_words, 0);
		rdchk(4'h0, 32'h0000400A);
		power_up_timer_run <= 1'b0;
		repeat (4) @(posedge ref_clk);
		attempt(32'h0000400A, 32'hAA, 32'h55);
		repeat (200) @(posedge ref_clk);
		check(n_words, 0);
		// permit bit clear: start must be refused
		attempt(32'h0000000A, 32'h55, 32'hAA);
		repeat (100) @(posedge ref_clk);
		check(n_words, 0);
		rdchk(4'h0, 32'h0000000A);
		// permit set but another operation selected: refused
		attempt(32'h00004005, 32'h55, 32'hAA);
		repeat (100) @(posedge ref_clk);
		check(n_words, 0);
		rdchk(4'h0, 32'h00004005);
		attempt(32'h0000400A, 32'h55, 32'hAA);
		rdchk(4'h0, 32'h0000C00A);
		n = 0;
		do
		begin
			repeat (20) @(posedge ref_clk);
			bus(1'b0, 4'h0, 32'h0);
			n++;
		end
		while (rd[15] !== 1'b0 && n < 100);
		check(rd, 32'h0000400A);
		check(n_words, 16);
		for (int i = 0; i < 16; i++)
		begin
			check(seen_addr[i], 24'h7FFC00 + 24'(2 * i));
			check(seen_data[i], 16'hA500 + 16'(i));
		end
		// second power-up after the run has finished: permit and latch count cleared
		arst_n <= 1'b0;
		repeat (2) @(posedge ref_clk);
		arst_n <= 1'b1;
		@(posedge ref_clk);
		rdchk(4'h0, 32'h00000000);
		rdchk(4'hC, 32'h00000000);
		report_and_stop;
	end
endmodule : debw_ctrl_bench
